// ==== hdl/pobl_loader.sv ====
// bitstream loader: active serial flash master, passive slave, jtag feed
// assumes pins sampled by clk_sys_in; the external config clock pin is
//   an ordinary input whose rising edges are found by three-flop sampling
`timescale 1ns/100ps
module pobl_loader #(
    parameter int unsigned WAKE_CYC   = pobl_pkg::WAKE_WAIT_CYC,
    parameter int unsigned OSC_DIV    = pobl_pkg::OSC_DIV_DEF,
    parameter int unsigned LOAD_WORDS = 16,
    parameter logic [31:0] SIG_WORD   = pobl_pkg::SIG_WORD_DEF
) (
    // clock and reset
    input  wire logic                    clk_sys_in,
    input  wire logic                    rst_n_in,
    // configuration straps and pins
    input  wire logic                    config_reset_n_in,
    input  wire pobl_pkg::pobl_mode_t    mode_sel_in,
    input  wire pobl_pkg::pobl_width_t   passive_width_in,
    input  wire logic                    security_en_in,
    input  wire logic                    use_ext_clk_in,
    input  wire logic                    external_config_clock_pin_in,
    // serial flash side
    output logic                         flash_sclk_out,
    output logic                         flash_cs_n_out,
    output logic                         flash_mosi_out,
    input  wire logic                    flash_miso_in,
    // passive and jtag serial feed
    input  wire logic                    passive_clk_in,
    input  wire logic                    passive_data_in,
    input  wire logic                    jtag_valid_in,
    input  wire logic                    jtag_bit_in,
    // configuration memory and status
    output pobl_pkg::pobl_cmem_wr_t      cmem_wr_out,
    output pobl_pkg::pobl_status_t       status_out
);
    import pobl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: three flops, change counts when 2nd and 3rd agree
    logic [2:0] rst_s_reg, eclk_s_reg, miso_s_reg, pclk_s_reg, pdat_s_reg;
    logic       rst_q_reg;                   // filtered reset level
    logic       eclk_q_reg;                  // filtered ext clock level
    logic       pclk_q_reg;                  // filtered passive clock level
    logic       miso_q_reg;
    logic       pdat_q_reg;

    // sampling of the reset, external clock, flash and passive pins; jtag inputs are used directly
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s_reg  <= 3'h0;
            eclk_s_reg <= 3'h0;
            miso_s_reg <= 3'h0;
            pclk_s_reg <= 3'h0;
            pdat_s_reg <= 3'h0;
            rst_q_reg  <= 1'b0;
            eclk_q_reg <= 1'b0;
            pclk_q_reg <= 1'b0;
            miso_q_reg <= 1'b0;
            pdat_q_reg <= 1'b0;
        end else begin
            rst_s_reg  <= {rst_s_reg[1:0], config_reset_n_in};
            eclk_s_reg <= {eclk_s_reg[1:0], external_config_clock_pin_in};
            miso_s_reg <= {miso_s_reg[1:0], flash_miso_in};
            pclk_s_reg <= {pclk_s_reg[1:0], passive_clk_in};
            pdat_s_reg <= {pdat_s_reg[1:0], passive_data_in};
            // only stages 1 and 2 are compared; stage 0 feeds stage 1 only
            if (rst_s_reg[1] == rst_s_reg[2])   rst_q_reg  <= rst_s_reg[2];
            if (eclk_s_reg[1] == eclk_s_reg[2]) eclk_q_reg <= eclk_s_reg[2];
            if (pclk_s_reg[1] == pclk_s_reg[2]) pclk_q_reg <= pclk_s_reg[2];
            if (miso_s_reg[1] == miso_s_reg[2]) miso_q_reg <= miso_s_reg[2];
            if (pdat_s_reg[1] == pdat_s_reg[2]) pdat_q_reg <= pdat_s_reg[2];
        end
    end

    // edge detection on filtered levels
    logic rst_d_reg, eclk_d_reg, pclk_d_reg;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_d_reg  <= 1'b0;
            eclk_d_reg <= 1'b0;
            pclk_d_reg <= 1'b0;
        end else begin
            rst_d_reg  <= rst_q_reg;
            eclk_d_reg <= eclk_q_reg;
            pclk_d_reg <= pclk_q_reg;
        end
    end
    wire logic rst_rise  = rst_q_reg & ~rst_d_reg;        // start trigger
    wire logic in_reset  = ~rst_q_reg;
    wire logic eclk_rise = eclk_q_reg & ~eclk_d_reg;
    wire logic pclk_rise = pclk_q_reg & ~pclk_d_reg;

    ////////////////////////////////////////////////////////////////////
    // internal oscillator stand-in: divider producing an enable pulse
    logic [7:0] osc_cnt_reg;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in)                                      osc_cnt_reg <= 8'h00;
        else if (osc_cnt_reg == 8'(OSC_DIV - 1))            osc_cnt_reg <= 8'h00;
        else                                                osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
    // one enable per half period of the flash clock
    wire logic osc_tick = (osc_cnt_reg == 8'(OSC_DIV - 1));
    wire logic act_tick = use_ext_clk_in ? eclk_rise : osc_tick;

    ////////////////////////////////////////////////////////////////////
    // load state machine, gray coded along the active path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAKE  = 3'b001,
        ST_WAIT  = 3'b011,
        ST_FREAD = 3'b010,
        ST_DATA  = 3'b110,
        ST_CHECK = 3'b111,
        ST_USER  = 3'b101,
        ST_HALT  = 3'b100
    } pobl_state_t;

    pobl_state_t state_reg;
    logic [31:0] wait_cnt_reg;               // wake delay counter
    logic [5:0]  hdr_cnt_reg;                // header bits left to shift
    logic [39:0] hdr_sh_reg;                 // command/address shifter
    logic        sclk_reg;                   // flash clock level
    logic [4:0]  bit_cnt_reg;                // bits into current word
    logic [31:0] word_sh_reg;
    logic [15:0] word_cnt_reg;
    logic        width_bad;

    // x16/x32 passive widths are locked out under security
    assign width_bad = security_en_in && (mode_sel_in == POBL_MODE_PASSIVE) &&
                       (passive_width_in == POBL_W_X16 ||
                        passive_width_in == POBL_W_X32);

    // one serial bit arrives per source edge; only x1 is modelled serially
    logic bit_stb, bit_val;
    always_comb begin
        bit_stb = 1'b0;
        bit_val = 1'b0;
        case (mode_sel_in)
            POBL_MODE_ACTIVE: begin
                bit_stb = act_tick && sclk_reg;                 // sample on fall
                bit_val = miso_q_reg;
            end
            POBL_MODE_PASSIVE: begin
                bit_stb = pclk_rise;
                bit_val = pdat_q_reg;
            end
            POBL_MODE_JTAG: begin
                bit_stb = jtag_valid_in;
                bit_val = jtag_bit_in;
            end
            default: begin
                bit_stb = 1'b0;
            end
        endcase
    end

    // sequencer
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg    <= ST_IDLE;
            wait_cnt_reg <= 32'h0000_0000;
            hdr_cnt_reg  <= 6'h00;
            hdr_sh_reg   <= 40'h00_0000_0000;
        end else if (in_reset) begin
            state_reg    <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (rst_rise && !width_bad) begin
                        if (mode_sel_in == POBL_MODE_ACTIVE) begin
                            state_reg   <= ST_WAKE;
                            hdr_sh_reg  <= {FLASH_WAKE_CMD, 32'h0000_0000};
                            hdr_cnt_reg <= HDR_BITS_WAKE;
                        end else begin
                            state_reg   <= ST_DATA;             // slave modes
                        end
                    end
                end
                ST_WAKE: begin
                    // shift out on falling flash clock
                    if (act_tick && sclk_reg) begin
                        hdr_sh_reg  <= {hdr_sh_reg[38:0], 1'b0};
                        hdr_cnt_reg <= hdr_cnt_reg - 6'h01;
                        if (hdr_cnt_reg == 6'h01) begin
                            state_reg    <= ST_WAIT;
                            wait_cnt_reg <= 32'h0000_0000;
                        end
                    end
                end
                ST_WAIT: begin
                    wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
                    if (wait_cnt_reg >= 32'(WAKE_CYC - 1)) begin
                        state_reg   <= ST_FREAD;
                        hdr_sh_reg  <= {FLASH_FREAD_CMD, FLASH_START_ADR,
                                        8'h00};
                        hdr_cnt_reg <= HDR_BITS_FREAD;
                    end
                end
                ST_FREAD: begin
                    if (act_tick && sclk_reg) begin
                        hdr_sh_reg  <= {hdr_sh_reg[38:0], 1'b0};
                        hdr_cnt_reg <= hdr_cnt_reg - 6'h01;
                        if (hdr_cnt_reg == 6'h01) state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    // sequential read continues until the image is in
                    if (bit_stb && bit_cnt_reg == 5'h1F &&
                        word_cnt_reg == 16'(LOAD_WORDS)) state_reg <= ST_CHECK;
                end
                ST_CHECK: begin
                    // last word holds the signature
                    if (word_sh_reg == SIG_WORD) state_reg <= ST_USER;
                    else                         state_reg <= ST_HALT;
                end
                default: begin
                    state_reg <= state_reg;                      // user or halt hold
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flash clock and select; clock idles low between commands
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in)
            sclk_reg <= 1'b0;
        else if (state_reg == ST_WAKE || state_reg == ST_FREAD ||
                 (state_reg == ST_DATA && mode_sel_in == POBL_MODE_ACTIVE)) begin
            if (act_tick) sclk_reg <= ~sclk_reg;
        end else
            sclk_reg <= 1'b0;
    end

    // output pins registered
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flash_sclk_out <= 1'b0;
            flash_cs_n_out <= 1'b1;
            flash_mosi_out <= 1'b0;
        end else begin
            flash_sclk_out <= sclk_reg;
            flash_mosi_out <= hdr_sh_reg[39];
            // select dropped during wait so the wake instruction completes
            flash_cs_n_out <= !(state_reg == ST_WAKE || state_reg == ST_FREAD ||
                               (state_reg == ST_DATA &&
                                mode_sel_in == POBL_MODE_ACTIVE));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bitstream assembly and memory write
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_reg  <= 5'h00;
            word_sh_reg  <= 32'h0000_0000;
            word_cnt_reg <= 16'h0000;
            cmem_wr_out  <= '0;
        end else if (in_reset || state_reg == ST_IDLE) begin
            bit_cnt_reg  <= 5'h00;
            word_cnt_reg <= 16'h0000;
            cmem_wr_out  <= '0;
        end else begin
            cmem_wr_out.wr <= 1'b0;
            if (state_reg == ST_DATA && bit_stb) begin
                word_sh_reg <= {word_sh_reg[30:0], bit_val};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (bit_cnt_reg == 5'h1F) begin
                    word_cnt_reg <= word_cnt_reg + 16'h0001;
                    // image words go to memory; the trailing signature does not
                    if (word_cnt_reg < 16'(LOAD_WORDS)) begin
                        cmem_wr_out.wr   <= 1'b1;
                        cmem_wr_out.addr <= word_cnt_reg;
                        cmem_wr_out.data <= {word_sh_reg[30:0], bit_val};
                    end
                end
            end
        end
    end

    // status from state
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in)
            status_out <= '0;
        else begin
            status_out.busy      <= (state_reg != ST_IDLE) &&
                                    (state_reg != ST_USER) && (state_reg != ST_HALT);
            status_out.user_mode <= (state_reg == ST_USER);
            status_out.sig_fail  <= (state_reg == ST_HALT);
            status_out.width_err <= width_bad;
        end
    end
endmodule

// ==== hdl/pobl_pkg.sv ====
// constants, types and mode codes shared by the bitstream loader
// assumes a single 125 MHz system clock; every other rate is an enable
//
// What this block does
// - reset rising edge starts active serial load
// - active clock from oscillator or external pin
// - send flash wake instruction before any read
// - wait at least 30 us after wake
// - fast read starts at 24-bit address zero
// - support active, passive and jtag loads
// - x16 and x32 refused in security mode
// - control block writes bitstream into memory
// - bad signature halts, good enters user mode
package pobl_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned WAKE_WAIT_US    = 30;
    localparam int unsigned WAKE_WAIT_CYC   =
        (WAKE_WAIT_US * (CLK_HZ / 1_000_000));        // least time, exact
    localparam int unsigned PASSIVE_WAIT_US = 32;
    localparam int unsigned PASSIVE_WAIT_CYC =
        (PASSIVE_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned OSC_DIV_DEF     = 4;      // internal osc divider

    // flash instructions and start address
    localparam logic [7:0]  FLASH_WAKE_CMD  = 8'hAB;
    localparam logic [7:0]  FLASH_FREAD_CMD = 8'h0B;
    localparam logic [23:0] FLASH_START_ADR = 24'h000000;
    localparam int unsigned FREAD_DUMMY_BITS = 8;
    localparam logic [5:0]  HDR_BITS_WAKE   = 6'h08;
    localparam logic [5:0]  HDR_BITS_FREAD  = 6'h28;  // cmd+addr+dummy

    // memory word and signature
    localparam int unsigned WORD_W          = 32;
    localparam logic [31:0] SIG_WORD_DEF    = 32'hA5C3_5A3C; // arbitrary

    // load mode select
    typedef enum logic [1:0] {
        POBL_MODE_ACTIVE  = 2'h0,
        POBL_MODE_PASSIVE = 2'h1,
        POBL_MODE_JTAG    = 2'h2
    } pobl_mode_t;

    // passive bus widths
    typedef enum logic [2:0] {
        POBL_W_X1 = 3'h0, POBL_W_X2 = 3'h1, POBL_W_X4 = 3'h2,
        POBL_W_X8 = 3'h3, POBL_W_X16 = 3'h4, POBL_W_X32 = 3'h5
    } pobl_width_t;

    // memory write carrier
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] data;
    } pobl_cmem_wr_t;

    // loader status carrier
    typedef struct packed {
        logic busy;
        logic user_mode;
        logic sig_fail;
        logic width_err;
    } pobl_status_t;
endpackage

// ==== test/pobl_flash_model.sv ====
// serial flash model answering wake and fast read
// assumes mode 0 clocking: sample on rise, shift out after fall
`timescale 1ns/100ps
module pobl_flash_model #(
    parameter realtime WAKE_NS = 160.0
) (
    // flash pins
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        mosi_in,
    output logic             miso_out,
    // stored image, first word in the top bits
    input  wire logic [95:0] image_in
);
    import pobl_pkg::*;
    int          n_in;   // bits taken this frame
    int          ptr;    // next image bit
    logic [7:0]  cmd;    // instruction byte
    logic [23:0] adr;    // read address
    logic        awake;  // woken, stays so
    logic        gap_ok; // wake wait honoured
    realtime     t_wake; // end of wake frame
    initial begin
        miso_out = 1'b0;
        awake = 1'b0;
        gap_ok = 1'b0;
        n_in = 0;
    end
    // instruction then address bits
    always @(posedge sclk_in) if (!cs_n_in) begin
        if (n_in < 8) cmd = {cmd[6:0], mosi_in};
        else if (n_in < 32) adr = {adr[22:0], mosi_in};
        n_in = n_in + 1;
    end
    // wake counts only as a whole frame; released line shows no stale bit
    always @(posedge cs_n_in) begin
        if (n_in == 8 && cmd == FLASH_WAKE_CMD) begin
            awake = 1'b1;
            t_wake = $realtime;
        end
        n_in = 0;
        miso_out = ~miso_out;
    end
    // a read too soon after wake gets garbage
    always @(negedge cs_n_in) gap_ok = awake && ($realtime - t_wake >= WAKE_NS);
    // data after the dummy byte, msb first
    always @(negedge sclk_in) if (!cs_n_in && n_in >= 40) begin
        ptr = int'(adr) * 8 + n_in - 40;
        if (gap_ok && cmd == FLASH_FREAD_CMD && ptr < 96) miso_out = image_in[95 - ptr];
        else miso_out = ~miso_out;
    end
endmodule

// ==== test/pobl_loader_asserts.sv ====
// port checker for the bitstream loader
// assumes it is bound onto every pobl_loader instance
`timescale 1ns/100ps
module pobl_loader_asserts #(
    parameter int unsigned WAKE_CYC = pobl_pkg::WAKE_WAIT_CYC
) (
    // clock, reset and pins
    input wire logic                    clk_sys_in,
    input wire logic                    rst_n_in,
    input wire logic                    config_reset_n_in,
    input wire pobl_pkg::pobl_mode_t    mode_sel_in,
    input wire logic                    security_en_in,
    input wire logic                    use_ext_clk_in,
    input wire logic                    external_config_clock_pin_in,
    // outputs watched
    input wire logic                    flash_sclk_out,
    input wire logic                    flash_cs_n_out,
    input wire logic                    flash_mosi_out,
    input wire pobl_pkg::pobl_cmem_wr_t cmem_wr_out,
    input wire pobl_pkg::pobl_status_t  status_out
);
    import pobl_pkg::*;
    logic [15:0] hi_cnt;  // cycles with chip select high
    logic [7:0]  bit_cnt; // bits seen in this frame
    logic [31:0] sh;      // last 32 bits on mosi
    logic [1:0]  frm;     // frames since release
    logic [3:0]  ext_age; // cycles since pin rise, saturating
    logic        sclk_d;  // previous flash clock
    logic        ext_d;   // previous pin level
    ////////////////////////////////////////////////////////////////
    // frame capture: bits taken on flash clock rise
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {hi_cnt, bit_cnt, sh, frm, sclk_d} <= '0;
        end else begin
            sclk_d <= flash_sclk_out;
            hi_cnt <= flash_cs_n_out ? hi_cnt + 16'h0001 : 16'h0000;
            if (flash_sclk_out && !sclk_d && !flash_cs_n_out) begin
                sh      <= {sh[30:0], flash_mosi_out};
                bit_cnt <= bit_cnt + 8'h01;
            end else if (flash_cs_n_out) begin
                bit_cnt <= 8'h00;
            end
            // frame count restarts with each release
            if (!config_reset_n_in) begin
                frm <= 2'h0;
            end else if (!flash_cs_n_out && hi_cnt != 16'h0000 && frm != 2'h3) begin
                frm <= frm + 2'h1;
            end
        end
    end
    // age of the last external pin rise
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {ext_age, ext_d} <= '0;
        end else begin
            ext_d   <= external_config_clock_pin_in;
            ext_age <= (external_config_clock_pin_in && !ext_d) ? 4'h0 :
                       (ext_age == 4'hF) ? ext_age : ext_age + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // a clean release after a held-low reset
    sequence s_release;
        (!config_reset_n_in)[*6] ##1 config_reset_n_in;
    endsequence
    // end of the first frame, the wake frame
    sequence s_wake_end;
        $rose(flash_cs_n_out) ##0 (frm == 2'h1);
    endsequence
    chk_start_busy: assert property (
        s_release ##0 !security_en_in |-> ##[1:10] status_out.busy)
        else $error("load did not start after release");
    chk_no_wr_reset: assert property (
        (!config_reset_n_in)[*8] |-> !cmem_wr_out.wr)
        else $error("memory write while reset held");
    chk_wake_gap: assert property (
        !flash_cs_n_out && hi_cnt != 16'h0000 && frm != 2'h0 |-> hi_cnt >= WAKE_CYC)
        else $error("read issued too soon after wake");
    chk_wake_byte: assert property (
        s_wake_end |-> bit_cnt == 8'h08 && sh[7:0] == FLASH_WAKE_CMD)
        else $error("first frame is not the wake instruction");
    chk_fread_hdr: assert property (
        frm == 2'h2 && bit_cnt == 8'h20 |-> sh == {FLASH_FREAD_CMD, FLASH_START_ADR})
        else $error("fast read header wrong");
    chk_user_excl: assert property (
        !(status_out.user_mode && status_out.sig_fail))
        else $error("user mode and signature failure together");
    chk_user_hold: assert property (
        (status_out.user_mode && config_reset_n_in)[*4] |=> status_out.user_mode)
        else $error("user mode dropped without reset");
    chk_wr_order: assert property (
        cmem_wr_out.wr |-> !status_out.user_mode && status_out.busy)
        else $error("memory write outside a load");
    chk_width_refuse: assert property (
        status_out.width_err |-> !status_out.busy && !cmem_wr_out.wr)
        else $error("refused width still loading");
    chk_ext_clk: assert property (
        $changed(flash_sclk_out) && use_ext_clk_in && mode_sel_in == POBL_MODE_ACTIVE
        && config_reset_n_in |-> ext_age <= 4'h8)
        else $error("flash clock moved without a pin edge");
endmodule

bind pobl_loader pobl_loader_asserts #(.WAKE_CYC(WAKE_CYC)) i_pobl_loader_asserts (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .config_reset_n_in(config_reset_n_in),
    .mode_sel_in(mode_sel_in), .security_en_in(security_en_in),
    .use_ext_clk_in(use_ext_clk_in),
    .external_config_clock_pin_in(external_config_clock_pin_in),
    .flash_sclk_out(flash_sclk_out), .flash_cs_n_out(flash_cs_n_out),
    .flash_mosi_out(flash_mosi_out), .cmem_wr_out(cmem_wr_out), .status_out(status_out));

// ==== test/tb_top.sv ====
// self-checking bench for the bitstream loader
// assumes the flash model and the checker are compiled alongside
`timescale 1ns/100ps
module tb_top;
    import pobl_pkg::*;
    localparam int unsigned WAKE = 20;                 // shortened wake wait
    localparam logic [63:0] DATA = 64'h1234_5678_9ABC_DEF0; // two words
    logic          clk_sys_in, rst_n_in, config_reset_n, sec, ext_sel, ext_pin;
    logic          ext_run, sclk, cs_n, mosi, miso, pclk, pdata, jv, jb;
    logic [95:0]   img;   // flash contents
    pobl_mode_t    mode;
    pobl_width_t   width;
    pobl_cmem_wr_t wr;
    pobl_status_t  st;
    logic [15:0]   wa [$]; // write log, addresses
    logic [31:0]   wd [$]; // write log, data
    int            n_mismatch = 0;
    int            comparisons = 0;
    pobl_loader #(.WAKE_CYC(WAKE), .LOAD_WORDS(2)) i_pobl_loader (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .config_reset_n_in(config_reset_n),
        .mode_sel_in(mode), .passive_width_in(width), .security_en_in(sec),
        .use_ext_clk_in(ext_sel), .external_config_clock_pin_in(ext_pin),
        .flash_sclk_out(sclk), .flash_cs_n_out(cs_n), .flash_mosi_out(mosi),
        .flash_miso_in(miso), .passive_clk_in(pclk), .passive_data_in(pdata),
        .jtag_valid_in(jv), .jtag_bit_in(jb), .cmem_wr_out(wr), .status_out(st));
    pobl_flash_model #(.WAKE_NS(WAKE * 8.0)) i_pobl_flash_model (.sclk_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .image_in(img));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // link clock, 64 ns, runs only while a load wants it
    initial begin
        ext_pin = 1'b0;
        forever begin
            repeat (4) @(negedge clk_sys_in);
            if (ext_run) ext_pin = ~ext_pin;
        end
    end
    // write pulse is logged mid-cycle, away from the edge that launches it
    always @(negedge clk_sys_in) if (wr.wr === 1'b1) begin
        wa.push_back(wr.addr);
        wd.push_back(wr.data);
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // hold reset low, log cleared past the input filter, then release
    task automatic restart(input pobl_mode_t m, input pobl_width_t w, input logic s);
        @(negedge clk_sys_in);
        config_reset_n = 1'b0;
        mode = m;
        width = w;
        sec = s;
        repeat (5) @(negedge clk_sys_in);
        wa.delete();
        wd.delete();
        repeat (5) @(negedge clk_sys_in);
        chk("writes in reset", 32'(wd.size()), 0);
        config_reset_n = 1'b1;
        for (int n = 0; n < 20 && st.busy !== 1'b1; n++) @(negedge clk_sys_in);
    endtask
    task automatic wait_done;
        for (int n = 0; n < 8000 && st.user_mode !== 1'b1 && st.sig_fail !== 1'b1; n++)
            @(negedge clk_sys_in);
    endtask
    // outcome and the words written
    task automatic judge(input logic good);
        chk("user_mode", 32'(st.user_mode), 32'(good));
        chk("sig_fail", 32'(st.sig_fail), 32'(!good));
        chk("word count", 32'(wd.size()), 2);
        for (int i = 0; i < 2 && i < wd.size(); i++) begin
            chk("addr", 32'(wa[i]), i);
            chk("data", wd[i], DATA[63 - 32 * i -: 32]);
        end
    endtask
    task automatic send_bits(input logic [95:0] b, input logic by_jtag);
        for (int i = 95; i >= 0; i--) begin
            pdata = b[i];
            jb = b[i];
            jv = by_jtag;
            pclk = 1'b0;
            repeat (by_jtag ? 1 : 4) @(negedge clk_sys_in);
            jv = 1'b0;
            pclk = !by_jtag;
            repeat (by_jtag ? 1 : 4) @(negedge clk_sys_in);
        end
        pclk = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // active load, optionally aborted by a second reset mid-header
    task automatic sc_active(input logic ext, input logic abort);
        ext_sel = ext;
        ext_run = ext;
        img = {DATA, SIG_WORD_DEF};
        restart(POBL_MODE_ACTIVE, POBL_W_X1, 1'b0);
        if (abort) begin
            repeat (300) @(negedge clk_sys_in);
            restart(POBL_MODE_ACTIVE, POBL_W_X1, 1'b0);
        end
        wait_done();
        judge(1'b1);
        ext_run = 1'b0;
    endtask
    task automatic sc_jtag_bad;
        restart(POBL_MODE_JTAG, POBL_W_X1, 1'b0);
        send_bits({DATA, ~SIG_WORD_DEF}, 1'b1);
        wait_done();
        judge(1'b0);
    endtask
    task automatic sc_passive;
        restart(POBL_MODE_PASSIVE, POBL_W_X1, 1'b0);
        repeat (PASSIVE_WAIT_CYC) @(negedge clk_sys_in);
        send_bits({DATA, SIG_WORD_DEF}, 1'b0);
        wait_done();
        judge(1'b1);
    endtask
    // wide passive widths refused in security mode
    task automatic sc_secure;
        for (int k = 0; k < 2; k++) begin
            restart(POBL_MODE_PASSIVE, k ? POBL_W_X32 : POBL_W_X16, 1'b1);
            chk("width_err", 32'(st.width_err), 1);
            chk("busy", 32'(st.busy), 0);
        end
    endtask
    initial begin
        {rst_n_in, config_reset_n, sec, ext_sel, ext_run, pclk, pdata, jv, jb} = '0;
        mode = POBL_MODE_ACTIVE;
        width = POBL_W_X1;
        img = '0;
        repeat (12) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        sc_active(1'b0, 1'b1);
        sc_active(1'b1, 1'b0);
        sc_jtag_bad();
        sc_passive();
        sc_secure();
        end_sim();
    end
    // watchdog, well past the roughly nine thousand cycles the run needs
    initial begin
        #200_000;
        n_mismatch++;
        end_sim();
    end
endmodule
